// [design/fcs_pkg.sv]
package fcs_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_CLKDIV = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_COMMAND_OBJECT_INDEX = 4'h2;
  localparam logic [3:0] ADDR_CCOB_HI = 4'h3;
  localparam logic [3:0] ADDR_CCOB_LO = 4'h4;
  localparam logic [3:0] ADDR_PROTECT = 4'h5;
  localparam logic [3:0] ADDR_MODE = 4'h6;
  // Clock divider fields
  localparam int DIV_LOADED_BIT = 7;
  localparam int DIV_LOCK_BIT = 6;
  localparam int DIV_WIDTH = 6;
  // Status fields
  localparam int ST_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ST_ACCESS_ERROR_BIT = 5;
  localparam int ST_PROTECTION_VIOLATION_BIT = 4;
  localparam int ST_MG1_BIT = 1;
  localparam int ST_MG0_BIT = 0;
  // Command codes and index values
  localparam logic [7:0] CMD_VERIFY_PFLASH_SECTION = 8'h03;
  localparam logic [7:0] CMD_VERIFY_EEPROM_SECTION = 8'h12;
  localparam logic [7:0] CMD_PROGRAM_EEPROM = 8'h11;
  localparam logic [2:0] IX_CMD = 3'h0;
  localparam logic [2:0] IX_ADDR = 3'h1;
  localparam logic [2:0] IX_COUNT = 3'h2;
  localparam logic [2:0] IX_WORD0 = 3'h2;
  localparam logic [2:0] IX_WORD3 = 3'h5;
  localparam int CCOB_WORDS = 6;
  // Array layout: EEPROM in global space, P-Flash block
  localparam logic [17:0] EE_BASE = 18'h00400;
  localparam logic [17:0] EE_SIZE_BYTES = 18'h00800;
  localparam logic [17:0] PF_BASE = 18'h30000;
  localparam logic [19:0] PF_END = 20'h40000;
  localparam logic [2:0] PHRASE_BYTES_LOG2 = 3'h3;
  // Erased cells read as ones
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  // Timebase
  localparam int TIMEBASE_MHZ = 1;
  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_PROG = 3'b010,
    ST_VERIFY_RD = 3'b011,
    ST_BLANK_RD = 3'b100,
    ST_DONE = 3'b101
  } fcs_state_type;
endpackage

// [design/fcs_array.sv]
`timescale 1ns/10ps
`default_nettype none
// Word-wide storage model of the array; read data come out of a register
module fcs_array
#(
  parameter int ADDR_WIDTH = 10
)
(
  // Clock
  input wire logic clk,
  // Port
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic write_en,
  input wire logic [15:0] write_data,
  output logic [15:0] read_data
);
  // Array starts erased, so blank checks see ones and not unknowns
  logic [15:0] mem [0:(1<<ADDR_WIDTH)-1] = '{default: fcs_pkg::ERASED_WORD};

  // Programming can only clear bits, as a real cell does
  always_ff @(posedge clk)
  begin
    if (write_en)
    begin
      mem[addr] <= mem[addr] & write_data;
    end
    read_data <= mem[addr];
  end
endmodule
`default_nettype wire

// [design/fcs_sequencer.sv]
// Function
// - Divider-loaded bit reads 0 until first write after reset, then 1.
// - Lock bit freezes divide field; only reset clears lock.
// - Commands and parameters enter through one indexed command object.
// - New command written only after the previous command finished.
// - Byte and aligned word reads in one cycle; the code has no byte reads and reads each array word over two cycles.
// - Erased bit reads 1, programmed bit reads 0.
// - EEPROM verify: access error if index not 010 or mode forbids.
// - EEPROM verify: access error on invalid 18-bit global address.
// - EEPROM verify: error if misaligned or past block end; no protection error.
// - Verify bits: hi on any read error/blank fail, lo on uncorrectable/blank fail.
// - Program EEPROM writes one to four erased words, then verifies them.
// - Index at launch sets how many words are programmed.
// - Clearing complete flag launches; protected area not programmed; flag sets at end.
// - P-Flash verify: code 0x03, address high, then first phrase address.
// - P-Flash section not erased sets both verify bits; flag sets after; the code treats P-Flash as erased and copies the read error inputs.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module fcs_sequencer
#(
  parameter int EE_AW = 10,
  parameter int BUS_MHZ = 100
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Array read error inputs from the storage's correction logic
  input wire logic read_error,
  input wire logic read_uncorrectable,
  // Timebase tick and busy
  output logic timebase_tick,
  output logic busy
);
  // Software state
  logic [7:0] flash_clock_divider;
  logic [7:0] next_flash_clock_divider;
  logic [2:0] command_object_index;
  logic [2:0] next_command_object_index;
  logic [15:0] command_object [0:fcs_pkg::CCOB_WORDS-1];
  logic [15:0] next_command_object [0:fcs_pkg::CCOB_WORDS-1];
  logic command_complete_flag, next_command_complete_flag;
  logic access_error, next_access_error;
  logic protection_violation, next_protection_violation;
  logic verify_status_hi, next_verify_status_hi;
  logic verify_status_lo, next_verify_status_lo;
  logic ee_protect, next_ee_protect;
  logic cmd_allowed, next_cmd_allowed;
  // Sequencer state
  fcs_pkg::fcs_state_type state, next_state;
  logic [2:0] launch_index, next_launch_index;
  logic [15:0] count, next_count;
  logic [EE_AW-1:0] word_ptr, next_word_ptr;
  logic [2:0] word_sel, next_word_sel;
  logic rd_pending, next_rd_pending;
  logic [15:0] reg_rdata_q, next_reg_rdata;
  logic [5:0] tb_count, next_tb_count;
  logic tick_q, next_tick;
  // Array port
  logic arr_we;
  logic [15:0] arr_rd;
  logic [15:0] arr_wd;

  // Global address assembled from object words 0 and 1
  function automatic logic [17:0] global_addr(input logic [15:0] w0, input logic [15:0] w1);
    global_addr = {w0[1:0], w1};
  endfunction

  // EEPROM range test used by the parameter check of both EEPROM commands
  function automatic logic in_eeprom(input logic [17:0] a);
    in_eeprom = (a >= fcs_pkg::EE_BASE) && (a < fcs_pkg::EE_BASE + fcs_pkg::EE_SIZE_BYTES);
  endfunction

  logic [17:0] gaddr;
  logic [17:0] ee_span_end;
  logic [19:0] pf_span_end;
  logic [17:0] prog_span_end;
  logic launch;
  assign gaddr = global_addr(command_object[fcs_pkg::IX_CMD], command_object[fcs_pkg::IX_ADDR]);
  // Byte end of the requested section; counts are words or phrases
  assign ee_span_end = gaddr + {1'b0, command_object[fcs_pkg::IX_COUNT], 1'b0};
  // Wide enough that the block end itself and long sections cannot wrap
  assign pf_span_end = 20'(gaddr) + 20'({command_object[fcs_pkg::IX_COUNT], 3'h0});
  // Program span follows the launch index, not the data held in word 0
  assign prog_span_end = gaddr
    + 18'({3'(launch_index - fcs_pkg::IX_WORD0 + 3'h1), 1'b0});
  // Writing one to the complete flag starts a command
  assign launch = reg_write && reg_addr == fcs_pkg::ADDR_STATUS
    && reg_wdata[fcs_pkg::ST_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag;

  fcs_array #(.ADDR_WIDTH(EE_AW)) u_array
  (
    .clk(clk),
    .addr(word_ptr),
    .write_en(arr_we),
    .write_data(arr_wd),
    .read_data(arr_rd)
  );

  // Register writes, status flags and the command sequencer
  always_comb
  begin
    next_flash_clock_divider = flash_clock_divider;
    next_command_object_index = command_object_index;
    for (int i = 0; i < fcs_pkg::CCOB_WORDS; i++)
    begin
      next_command_object[i] = command_object[i];
    end
    next_command_complete_flag = command_complete_flag;
    next_access_error = access_error;
    next_protection_violation = protection_violation;
    next_verify_status_hi = verify_status_hi;
    next_verify_status_lo = verify_status_lo;
    next_ee_protect = ee_protect;
    next_cmd_allowed = cmd_allowed;
    next_state = state;
    next_launch_index = launch_index;
    next_count = count;
    next_word_ptr = word_ptr;
    next_word_sel = word_sel;
    arr_we = 1'b0;
    arr_wd = fcs_pkg::ERASED_WORD;
    if (reg_write)
    begin
      case (reg_addr)
        fcs_pkg::ADDR_CLKDIV:
        begin
          next_flash_clock_divider[fcs_pkg::DIV_LOADED_BIT] = 1'b1;
          if (!flash_clock_divider[fcs_pkg::DIV_LOCK_BIT])
          begin
            next_flash_clock_divider[fcs_pkg::DIV_WIDTH-1:0] =
              reg_wdata[fcs_pkg::DIV_WIDTH-1:0];
            next_flash_clock_divider[fcs_pkg::DIV_LOCK_BIT] =
              reg_wdata[fcs_pkg::DIV_LOCK_BIT];
          end
        end
        fcs_pkg::ADDR_STATUS:
        begin
          // Error flags clear by writing one, only while idle
          if (command_complete_flag)
          begin
            if (reg_wdata[fcs_pkg::ST_ACCESS_ERROR_BIT])
            begin
              next_access_error = 1'b0;
            end
            if (reg_wdata[fcs_pkg::ST_PROTECTION_VIOLATION_BIT])
            begin
              next_protection_violation = 1'b0;
            end
          end
        end
        fcs_pkg::ADDR_COMMAND_OBJECT_INDEX:
        begin
          if (command_complete_flag)
          begin
            next_command_object_index = reg_wdata[2:0];
          end
        end
        fcs_pkg::ADDR_CCOB_HI, fcs_pkg::ADDR_CCOB_LO:
        begin
          // Object is frozen while a command runs
          if (command_complete_flag && command_object_index < 3'(fcs_pkg::CCOB_WORDS))
          begin
            next_command_object[command_object_index] = reg_wdata;
          end
        end
        fcs_pkg::ADDR_PROTECT:
        begin
          next_ee_protect = reg_wdata[0];
        end
        fcs_pkg::ADDR_MODE:
        begin
          next_cmd_allowed = reg_wdata[0];
        end
        default:
        begin
        end
      endcase
    end
    case (state)
      fcs_pkg::ST_IDLE:
      begin
        if (launch)
        begin
          next_command_complete_flag = 1'b0;
          next_launch_index = command_object_index;
          next_verify_status_hi = 1'b0;
          next_verify_status_lo = 1'b0;
          next_state = fcs_pkg::ST_CHECK;
        end
      end
      fcs_pkg::ST_CHECK:
      begin
        next_state = fcs_pkg::ST_DONE;
        next_word_sel = fcs_pkg::IX_WORD0;
        next_word_ptr = EE_AW'((gaddr - fcs_pkg::EE_BASE) >> 1);
        case (command_object[fcs_pkg::IX_CMD][15:8])
          fcs_pkg::CMD_VERIFY_EEPROM_SECTION:
          begin
            if (launch_index != fcs_pkg::IX_COUNT || !cmd_allowed
              || !in_eeprom(gaddr)
              || gaddr[0] || ee_span_end > fcs_pkg::EE_BASE + fcs_pkg::EE_SIZE_BYTES)
            begin
              next_access_error = 1'b1;
            end
            else
            begin
              next_count = command_object[fcs_pkg::IX_COUNT];
              next_state = fcs_pkg::ST_BLANK_RD;
            end
          end
          fcs_pkg::CMD_PROGRAM_EEPROM:
          begin
            if (launch_index < fcs_pkg::IX_WORD0 || launch_index > fcs_pkg::IX_WORD3
              || !cmd_allowed || !in_eeprom(gaddr) || gaddr[0]
              || prog_span_end > fcs_pkg::EE_BASE + fcs_pkg::EE_SIZE_BYTES)
            begin
              next_access_error = 1'b1;
            end
            else if (ee_protect)
            begin
              next_protection_violation = 1'b1;
            end
            else
            begin
              next_count = 16'(launch_index - fcs_pkg::IX_WORD0) + 16'h0001;
              next_state = fcs_pkg::ST_PROG;
            end
          end
          fcs_pkg::CMD_VERIFY_PFLASH_SECTION:
          begin
            // P-Flash content lies outside this block; treated as erased
            if (launch_index != fcs_pkg::IX_COUNT || !cmd_allowed
              || gaddr < fcs_pkg::PF_BASE || gaddr[fcs_pkg::PHRASE_BYTES_LOG2-1:0] != 3'h0
              || pf_span_end > fcs_pkg::PF_END)
            begin
              next_access_error = 1'b1;
            end
            else
            begin
              next_verify_status_hi = read_error;
              next_verify_status_lo = read_uncorrectable;
            end
          end
          default:
          begin
            next_access_error = 1'b1;
          end
        endcase
      end
      fcs_pkg::ST_PROG:
      begin
        arr_we = 1'b1;
        arr_wd = command_object[word_sel];
        next_state = fcs_pkg::ST_VERIFY_RD;
      end
      fcs_pkg::ST_VERIFY_RD:
      begin
        // Read data of the programmed word are valid now
        if (rd_pending)
        begin
          if (arr_rd != command_object[word_sel])
          begin
            next_verify_status_hi = 1'b1;
            next_verify_status_lo = 1'b1;
          end
          next_count = count - 16'h0001;
          next_word_ptr = word_ptr + 1'b1;
          next_word_sel = word_sel + 3'h1;
          next_state = (count == 16'h0001) ? fcs_pkg::ST_DONE : fcs_pkg::ST_PROG;
        end
      end
      fcs_pkg::ST_BLANK_RD:
      begin
        if (count == 16'h0000)
        begin
          next_state = fcs_pkg::ST_DONE;
        end
        else if (rd_pending)
        begin
          if (read_error || arr_rd != fcs_pkg::ERASED_WORD)
          begin
            next_verify_status_hi = 1'b1;
          end
          if (read_uncorrectable || arr_rd != fcs_pkg::ERASED_WORD)
          begin
            next_verify_status_lo = 1'b1;
          end
          next_count = count - 16'h0001;
          next_word_ptr = word_ptr + 1'b1;
        end
      end
      fcs_pkg::ST_DONE:
      begin
        next_command_complete_flag = 1'b1;
        next_state = fcs_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = fcs_pkg::ST_IDLE;
      end
    endcase
  end

  // Read pending toggles so every array read gets one full cycle
  always_comb
  begin
    next_rd_pending = 1'b0;
    if ((state == fcs_pkg::ST_VERIFY_RD || state == fcs_pkg::ST_BLANK_RD) && !rd_pending)
    begin
      next_rd_pending = 1'b1;
    end
  end

  // Read data one cycle after the strobe
  always_comb
  begin
    next_reg_rdata = 16'h0000;
    if (reg_read)
    begin
      case (reg_addr)
        fcs_pkg::ADDR_CLKDIV: next_reg_rdata = {8'h00, flash_clock_divider};
        fcs_pkg::ADDR_STATUS:
        begin
          next_reg_rdata[fcs_pkg::ST_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
          next_reg_rdata[fcs_pkg::ST_ACCESS_ERROR_BIT] = access_error;
          next_reg_rdata[fcs_pkg::ST_PROTECTION_VIOLATION_BIT] = protection_violation;
          next_reg_rdata[fcs_pkg::ST_MG1_BIT] = verify_status_hi;
          next_reg_rdata[fcs_pkg::ST_MG0_BIT] = verify_status_lo;
        end
        fcs_pkg::ADDR_COMMAND_OBJECT_INDEX: next_reg_rdata = {13'h0000, command_object_index};
        fcs_pkg::ADDR_CCOB_HI, fcs_pkg::ADDR_CCOB_LO:
          next_reg_rdata = (command_object_index < 3'(fcs_pkg::CCOB_WORDS))
            ? command_object[command_object_index] : 16'h0000;
        fcs_pkg::ADDR_PROTECT: next_reg_rdata = {15'h0000, ee_protect};
        fcs_pkg::ADDR_MODE: next_reg_rdata = {15'h0000, cmd_allowed};
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // Timebase divider: divide value plus one bus cycles per tick
  always_comb
  begin
    next_tick = 1'b0;
    next_tb_count = tb_count + 6'h01;
    if (tb_count >= flash_clock_divider[fcs_pkg::DIV_WIDTH-1:0])
    begin
      next_tb_count = 6'h00;
      next_tick = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flash_clock_divider <= 8'h00;
      command_object_index <= 3'h0;
      for (int i = 0; i < fcs_pkg::CCOB_WORDS; i++)
      begin
        command_object[i] <= 16'h0000;
      end
      command_complete_flag <= 1'b1;
      access_error <= 1'b0;
      protection_violation <= 1'b0;
      verify_status_hi <= 1'b0;
      verify_status_lo <= 1'b0;
      ee_protect <= 1'b0;
      cmd_allowed <= 1'b1;
      state <= fcs_pkg::ST_IDLE;
      launch_index <= 3'h0;
      count <= 16'h0000;
      word_ptr <= '0;
      word_sel <= 3'h0;
      rd_pending <= 1'b0;
      reg_rdata_q <= 16'h0000;
      tb_count <= 6'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      flash_clock_divider <= next_flash_clock_divider;
      command_object_index <= next_command_object_index;
      for (int i = 0; i < fcs_pkg::CCOB_WORDS; i++)
      begin
        command_object[i] <= next_command_object[i];
      end
      command_complete_flag <= next_command_complete_flag;
      access_error <= next_access_error;
      protection_violation <= next_protection_violation;
      verify_status_hi <= next_verify_status_hi;
      verify_status_lo <= next_verify_status_lo;
      ee_protect <= next_ee_protect;
      cmd_allowed <= next_cmd_allowed;
      state <= next_state;
      launch_index <= next_launch_index;
      count <= next_count;
      word_ptr <= next_word_ptr;
      word_sel <= next_word_sel;
      rd_pending <= next_rd_pending;
      reg_rdata_q <= next_reg_rdata;
      tb_count <= next_tb_count;
      tick_q <= next_tick;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign timebase_tick = tick_q;
  assign busy = !command_complete_flag;

  // Lock, once set, holds until reset
  property p_lock_sticky;
    @(posedge clk) disable iff (!reset_n)
    flash_clock_divider[fcs_pkg::DIV_LOCK_BIT] |=> flash_clock_divider[fcs_pkg::DIV_LOCK_BIT];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit dropped");

  property p_loaded_on_write;
    @(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == fcs_pkg::ADDR_CLKDIV |=>
      flash_clock_divider[fcs_pkg::DIV_LOADED_BIT];
  endproperty
  a_loaded_on_write: assert property (p_loaded_on_write) else $error("loaded bit not set");

  property p_locked_div_frozen;
    @(posedge clk) disable iff (!reset_n)
    flash_clock_divider[fcs_pkg::DIV_LOCK_BIT] |=>
      $stable(flash_clock_divider[fcs_pkg::DIV_WIDTH-1:0]);
  endproperty
  a_locked_div_frozen: assert property (p_locked_div_frozen) else $error("divide changed");

  property p_launch_clears_flag;
    @(posedge clk) disable iff (!reset_n)
    launch |=> !command_complete_flag && state == fcs_pkg::ST_CHECK;
  endproperty
  a_launch_clears_flag: assert property (p_launch_clears_flag) else $error("no launch");

  property p_error_no_write;
    @(posedge clk) disable iff (!reset_n)
    state == fcs_pkg::ST_CHECK && next_access_error && !access_error |=>
      !arr_we [*2] ##0 command_complete_flag;
  endproperty
  a_error_no_write: assert property (p_error_no_write) else $error("error path wrong");

  property p_done_within;
    @(posedge clk) disable iff (!reset_n)
    $fell(command_complete_flag) && state == fcs_pkg::ST_CHECK && launch_index ==
      fcs_pkg::IX_WORD0 && next_state == fcs_pkg::ST_PROG |-> ##[1:8] command_complete_flag;
  endproperty
  a_done_within: assert property (p_done_within) else $error("one word not done");

  property p_object_frozen;
    @(posedge clk) disable iff (!reset_n)
    !command_complete_flag |=> $stable(command_object[fcs_pkg::IX_CMD]);
  endproperty
  a_object_frozen: assert property (p_object_frozen) else $error("object changed");

  property p_read_data;
    @(posedge clk) disable iff (!reset_n)
    reg_read && reg_addr == fcs_pkg::ADDR_COMMAND_OBJECT_INDEX |=>
      reg_rdata[2:0] == $past(command_object_index);
  endproperty
  a_read_data: assert property (p_read_data) else $error("index readback wrong");
endmodule
`default_nettype wire

// [testbench/fcs_store_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Storage side of the sequencer: reports read faults only while a command runs
module fcs_store_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command activity and fault selection
  input wire logic busy,
  input wire logic [1:0] inject,
  // Fault reports toward the sequencer
  output logic read_error,
  output logic read_uncorrectable
);
  logic [1:0] fault;

  // Fault selection is registered; it is set up long before a launch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault <= 2'h0;
    end
    else
    begin
      fault <= inject;
    end
  end

  // Gated by busy directly, so the one-cycle parameter check already sees it
  // An uncorrectable fault is also a read fault, so it raises both lines
  assign read_error = busy & (fault[0] | fault[1]);
  assign read_uncorrectable = busy & fault[1];
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // Clock, reset and register port
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic read_error;
  logic read_uncorrectable;
  logic timebase_tick;
  logic busy;
  logic [1:0] inject = 2'h0;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h196424F7;
  logic [15:0] w [4] = '{16'h0004, 16'h0000, 16'h0000, 16'h0000};
  logic [17:0] bad_a [4] = '{18'h00401, 18'h00400, 18'h00BFC, 18'h00000};
  logic [2:0] bad_i [4] = '{3'h2, 3'h1, 3'h2, 3'h2};
  logic [15:0] dv;
  int n1;
  int n4;
  int k;

  always #5 clk = ~clk;

  fcs_sequencer i_fcs_sequencer (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .read_error(read_error),
    .read_uncorrectable(read_uncorrectable), .timebase_tick(timebase_tick), .busy(busy));

  fcs_store_model i_fcs_store_model (.clk(clk), .reset_n(reset_n), .busy(busy),
    .inject(inject), .read_error(read_error), .read_uncorrectable(read_uncorrectable));

  // Galois-free shift register keeps the run repeatable
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction

  // Expected status word with the complete flag set
  function automatic logic [15:0] st(input logic a, input logic p, input logic h,
    input logic l);
    return {8'h00, 1'b1, 1'b0, a, p, 2'b00, h, l};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic chk_reg(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask

  // Load the object, launch, optionally poke the index while busy, wait bounded
  task automatic run(input logic [7:0] cmd, input logic [17:0] ad, input logic [2:0] ix,
    input logic poke, output int n);
    realtime t0;
    wr(4'h1, 16'h0030);
    wr(4'h2, 16'h0000);
    wr(4'h3, {cmd, 6'h00, ad[17:16]});
    wr(4'h2, 16'h0001);
    wr(4'h3, ad[15:0]);
    for (int i = 2; i <= 5; i++)
    begin
      wr(4'h2, 16'(i));
      wr(4'h3, w[i-2]);
    end
    wr(4'h2, {13'h0000, ix});
    wr(4'h1, 16'h0080);
    t0 = $realtime;
    if (poke)
      wr(4'h2, 16'h0000);
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 300)
    begin
      num_errors++;
      test_done();
    end
    n = int'(($realtime - t0) / 10.0);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    chk_reg("divider", 4'h0, 16'h0000);
    chk_reg("status", 4'h1, st(0, 0, 0, 0));
    chk_reg("unmapped", 4'hF, 16'h0000);
    dv = rnd() & 16'h000F;
    wr(4'h0, dv);
    chk_reg("divider", 4'h0, 16'h0080 | dv);
    k = 0;
    while (timebase_tick !== 1'b1 && k < 100)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 100)
    begin
      num_errors++;
      test_done();
    end
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (timebase_tick !== 1'b1 && k < 100);
    if (k >= 100)
    begin
      num_errors++;
      test_done();
    end
    check("tick", 16'(k), dv + 16'h0001);
    wr(4'h0, 16'h0047);
    wr(4'h0, 16'h0003);
    chk_reg("lock", 4'h0, 16'h00C7);
    $display("divider test done");
    for (int i = 0; i < 4; i++)
    begin
      run(8'h12, bad_a[i], bad_i[i], 1'b0, n1);
      chk_reg("ee_err", 4'h1, st(1, 0, 0, 0));
    end
    wr(4'h6, 16'h0000);
    run(8'h12, 18'h00400, 3'h2, 1'b0, n1);
    chk_reg("mode", 4'h1, st(1, 0, 0, 0));
    wr(4'h6, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      inject = i[1:0];
      run(8'h12, 18'h00400, 3'h2, 1'b0, n1);
      chk_reg("ee_ver", 4'h1, st(0, 0, inject != 2'h0, inject[1]));
    end
    inject = 2'h0;
    $display("eeprom verify test done");
    w[0] = 16'h0002;
    run(8'h03, 18'h30000, 3'h2, 1'b0, n1);
    chk_reg("pf_ok", 4'h1, st(0, 0, 0, 0));
    run(8'h03, 18'h30004, 3'h2, 1'b0, n1);
    chk_reg("pf_mis", 4'h1, st(1, 0, 0, 0));
    inject = 2'h3;
    run(8'h03, 18'h30000, 3'h2, 1'b0, n1);
    chk_reg("pf_fail", 4'h1, st(0, 0, 1, 1));
    inject = 2'h0;
    $display("pflash verify test done");
    for (int i = 0; i < 4; i++)
      w[i] = rnd() & 16'hFFFE;
    run(8'h11, 18'h00400, 3'h2, 1'b0, n1);
    chk_reg("prog1", 4'h1, st(0, 0, 0, 0));
    run(8'h11, 18'h00410, 3'h5, 1'b1, n4);
    chk_reg("prog4", 4'h1, st(0, 0, 0, 0));
    chk_reg("index", 4'h2, 16'h0005);
    check("words", 16'(n4 - n1), 16'h0009);
    w[0] = 16'h0004;
    run(8'h12, 18'h00410, 3'h2, 1'b0, n1);
    chk_reg("blank", 4'h1, st(0, 0, 1, 1));
    wr(4'h5, 16'h0001);
    run(8'h11, 18'h00420, 3'h5, 1'b0, n1);
    chk_reg("prot", 4'h1, st(0, 1, 0, 0));
    wr(4'h5, 16'h0000);
    wr(4'h6, 16'h0000);
    run(8'h11, 18'h00430, 3'h5, 1'b0, n1);
    chk_reg("prog_mode", 4'h1, st(1, 0, 0, 0));
    wr(4'h6, 16'h0001);
    w[0] = 16'h0010;
    run(8'h12, 18'h00420, 3'h2, 1'b0, n1);
    chk_reg("untouched", 4'h1, st(0, 0, 0, 0));
    $display("program test done");
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wr(4'h0, 16'h0005);
    chk_reg("relock", 4'h0, 16'h0085);
    $display("reset test done");
    test_done();
  end
endmodule
`default_nettype wire
